/* src/stpcr_regs.sv */
// Split transaction and power management capability registers over APB
`timescale 1ns/10ps
`include "stpcr_consts.svh"

module stpcr_regs
    import stpcr_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`STPCR_ADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  stpcr_split_t                  up_req,
    input  stpcr_split_t                  up_cpl,
    output logic                          up_fwd,
    input  stpcr_split_t                  dn_req,
    input  stpcr_split_t                  dn_cpl,
    output logic                          dn_fwd
);

    // ------------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic wr_take;
    logic hit_up;
    logic hit_dn;
    logic hit_pm;
    logic hit_stat;
    logic hit_load;
    logic mapped;

    always_comb begin
        setup_ph  = psel && !penable;
        access_ph = psel && penable;
        wr_take   = access_ph && pwrite;
        hit_up    = (paddr == `STPCR_OFF_UP_SPLIT);
        hit_dn    = (paddr == `STPCR_OFF_DN_SPLIT);
        hit_pm    = (paddr == `STPCR_OFF_PM_CAP);
        hit_stat  = (paddr == `STPCR_OFF_SPLIT_STAT);
        hit_load  = (paddr == `STPCR_OFF_SPLIT_LOAD);
        mapped    = hit_up || hit_dn || hit_pm || hit_stat || hit_load;
    end

    // Read data is captured in setup, so every access is zero-wait
    assign pready = 1'b1;

    // ------------------------------------------------------------------
    // Commitment limits
    // ------------------------------------------------------------------
    logic [15:0] up_lim_ff;
    logic [15:0] dn_lim_ff;
    logic [15:0] nxt_up_lim;
    logic [15:0] nxt_dn_lim;

    always_comb begin
        nxt_up_lim = up_lim_ff;
        nxt_dn_lim = dn_lim_ff;
        // Only the upper half of each split word takes write data
        if (wr_take && hit_up) begin
            if (pstrb[2]) begin
                nxt_up_lim[7:0] = pwdata[23:16];
            end
            if (pstrb[3]) begin
                nxt_up_lim[15:8] = pwdata[31:24];
            end
        end
        if (wr_take && hit_dn) begin
            if (pstrb[2]) begin
                nxt_dn_lim[7:0] = pwdata[23:16];
            end
            if (pstrb[3]) begin
                nxt_dn_lim[15:8] = pwdata[31:24];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_lim_ff <= `STPCR_SPLIT_LIM_RST;
            dn_lim_ff <= `STPCR_SPLIT_LIM_RST;
        end else begin
            up_lim_ff <= nxt_up_lim;
            dn_lim_ff <= nxt_dn_lim;
        end
    end

    // ------------------------------------------------------------------
    // Per-direction limit checks
    // ------------------------------------------------------------------
    logic [1:0]         fwd_vec;
    logic [1:0]         dly_vec;
    logic [1:0][15:0]   load_vec;
    logic [1:0][15:0]   lim_vec;
    stpcr_split_t [1:0] req_vec;
    stpcr_split_t [1:0] cpl_vec;

    always_comb begin
        lim_vec[STPCR_DIR_UP] = up_lim_ff;
        lim_vec[STPCR_DIR_DN] = dn_lim_ff;
        req_vec[STPCR_DIR_UP] = up_req;
        req_vec[STPCR_DIR_DN] = dn_req;
        cpl_vec[STPCR_DIR_UP] = up_cpl;
        cpl_vec[STPCR_DIR_DN] = dn_cpl;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dir
            stpcr_limit_chk u_chk (
                .ref_clk (ref_clk),
                .rst_b   (rst_b),
                .limit   (lim_vec[gi]),
                .req     (req_vec[gi]),
                .cpl     (cpl_vec[gi]),
                .fwd     (fwd_vec[gi]),
                .delayed (dly_vec[gi]),
                .load    (load_vec[gi])
            );
        end
    endgenerate

    // Held requests simply see no forward strobe until room frees up
    assign up_fwd = fwd_vec[STPCR_DIR_UP];
    assign dn_fwd = fwd_vec[STPCR_DIR_DN];

    // ------------------------------------------------------------------
    // Split-request-delayed flags
    // ------------------------------------------------------------------
    logic [1:0] dly_ff;
    logic [1:0] nxt_dly;
    logic [1:0] dly_clr;

    always_comb begin
        dly_clr = 2'h0;
        if (wr_take && hit_stat) begin
            if (pstrb[0]) begin
                dly_clr[0] = pwdata[`STPCR_STAT_UP_BIT];
                dly_clr[1] = pwdata[`STPCR_STAT_DN_BIT];
            end
        end
        // A new delay in the clearing cycle keeps the flag set
        nxt_dly = (dly_ff & ~dly_clr) | dly_vec;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_ff <= 2'h0;
        end else begin
            dly_ff <= nxt_dly;
        end
    end

    // ------------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------------
    logic [31:0] up_word;
    logic [31:0] dn_word;
    logic [31:0] pm_word;
    logic [31:0] stat_word;
    logic [31:0] load_word;

    always_comb begin
        up_word = 32'h0;
        up_word[`STPCR_SPLIT_CAP_LSB +: 16] = `STPCR_SPLIT_CAP_VAL;
        up_word[`STPCR_SPLIT_LIM_LSB +: 16] = up_lim_ff;

        dn_word = 32'h0;
        dn_word[`STPCR_SPLIT_CAP_LSB +: 16] = `STPCR_SPLIT_CAP_VAL;
        dn_word[`STPCR_SPLIT_LIM_LSB +: 16] = dn_lim_ff;

        // Every field is a constant: no storage, so writes cannot land
        pm_word = 32'h0;
        pm_word[`STPCR_PM_ID_LSB  +: 8] = `STPCR_PM_ID_VAL;
        pm_word[`STPCR_PM_NXT_LSB +: 8] = `STPCR_PM_NXT_VAL;
        pm_word[`STPCR_PM_VER_LSB +: 3] = `STPCR_PM_VER_VAL;
        pm_word[`STPCR_PM_CLK_BIT]      = `STPCR_PM_CLK_VAL;
        pm_word[`STPCR_PM_RSV_BIT]      = 1'b0;
        pm_word[`STPCR_PM_DSI_BIT]      = `STPCR_PM_DSI_VAL;
        // Aux current encoding is not modelled; reads as zero
        pm_word[`STPCR_PM_AUX_LSB +: 3] = `STPCR_PM_AUX_VAL;
        pm_word[`STPCR_PM_D1_BIT]       = `STPCR_PM_D1_VAL;
        pm_word[`STPCR_PM_D2_BIT]       = `STPCR_PM_D2_VAL;
        pm_word[`STPCR_PM_EVT_LSB +: 5] = `STPCR_PM_EVT_VAL;

        stat_word = 32'h0;
        stat_word[`STPCR_STAT_UP_BIT] = dly_ff[STPCR_DIR_UP];
        stat_word[`STPCR_STAT_DN_BIT] = dly_ff[STPCR_DIR_DN];

        load_word = 32'h0;
        load_word[`STPCR_LOAD_UP_LSB +: 16] = load_vec[STPCR_DIR_UP];
        load_word[`STPCR_LOAD_DN_LSB +: 16] = load_vec[STPCR_DIR_DN];
    end

    // ------------------------------------------------------------------
    // Read data and error response
    // ------------------------------------------------------------------
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        err_ff;
    logic        nxt_err;

    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;
        if (setup_ph) begin
            nxt_err = !mapped;
            if (pwrite) begin
                nxt_rdata = 32'h0;
            end else if (hit_up) begin
                nxt_rdata = up_word;
            end else if (hit_dn) begin
                nxt_rdata = dn_word;
            end else if (hit_pm) begin
                nxt_rdata = pm_word;
            end else if (hit_stat) begin
                nxt_rdata = stat_word;
            end else if (hit_load) begin
                nxt_rdata = load_word;
            end else begin
                nxt_rdata = 32'h0;
            end
        end else if (!psel) begin
            nxt_err = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0;
            err_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    assign prdata  = rdata_ff;
    assign pslverr = err_ff && access_ph;

endmodule : stpcr_regs

/* src/stpcr_consts.svh */
// Offsets, field positions, reset values of the split/PM capability group
`ifndef STPCR_CONSTS_SVH
`define STPCR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define STPCR_OFF_UP_SPLIT      12'h088
`define STPCR_OFF_DN_SPLIT      12'h08c
`define STPCR_OFF_PM_CAP        12'h090
`define STPCR_OFF_SPLIT_STAT    12'h080
`define STPCR_OFF_SPLIT_LOAD    12'h07c
`define STPCR_ADDR_W            12

// ----------------------------------------------------------------------
// Split register fields
// ----------------------------------------------------------------------
`define STPCR_SPLIT_CAP_LSB     0
`define STPCR_SPLIT_LIM_LSB     16
`define STPCR_SPLIT_CAP_VAL     16'h0010
`define STPCR_SPLIT_LIM_RST     16'h0010
`define STPCR_SPLIT_NO_LIMIT    16'hffff

// ----------------------------------------------------------------------
// Power management capability header fields
// ----------------------------------------------------------------------
`define STPCR_PM_ID_LSB         0
`define STPCR_PM_NXT_LSB        8
`define STPCR_PM_VER_LSB        16
`define STPCR_PM_CLK_BIT        19
`define STPCR_PM_RSV_BIT        20
`define STPCR_PM_DSI_BIT        21
`define STPCR_PM_AUX_LSB        22
`define STPCR_PM_D1_BIT         25
`define STPCR_PM_D2_BIT         26
`define STPCR_PM_EVT_LSB        27
`define STPCR_PM_ID_VAL         8'h01
`define STPCR_PM_NXT_VAL        8'ha8
`define STPCR_PM_VER_VAL        3'h2
`define STPCR_PM_CLK_VAL        1'h0
`define STPCR_PM_DSI_VAL        1'h0
`define STPCR_PM_AUX_VAL        3'h0
`define STPCR_PM_D1_VAL         1'h0
`define STPCR_PM_D2_VAL         1'h0
`define STPCR_PM_EVT_VAL        5'h19

// ----------------------------------------------------------------------
// Own status register fields
// ----------------------------------------------------------------------
`define STPCR_STAT_UP_BIT       0
`define STPCR_STAT_DN_BIT       1
`define STPCR_LOAD_UP_LSB       0
`define STPCR_LOAD_DN_LSB       16

`endif

/* src/stpcr_pkg.sv */
// Types shared by the split/PM capability register group
package stpcr_pkg;

    // Split request offered for forwarding, or completion space released
    typedef struct packed {
        logic        valid;
        logic [15:0] size;
    } stpcr_split_t;

    // Direction index of the two split paths
    typedef enum logic {
        STPCR_DIR_UP,
        STPCR_DIR_DN
    } stpcr_dir_t;

endpackage : stpcr_pkg

/* src/stpcr_limit_chk.sv */
// Commitment limit check and outstanding ADQ accounting for one direction
`timescale 1ns/10ps
`include "stpcr_consts.svh"

module stpcr_limit_chk
    import stpcr_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [15:0]  limit,
    input  stpcr_split_t      req,
    input  stpcr_split_t      cpl,
    output logic              fwd,
    output logic              delayed,
    output logic [15:0]       load
);

    logic [15:0] load_ff;
    logic [15:0] nxt_load;
    logic [16:0] want;
    logic [16:0] sum;
    logic        no_limit;
    logic        fits;

    always_comb begin
        no_limit = (limit == `STPCR_SPLIT_NO_LIMIT);
        want     = {1'b0, load_ff} + {1'b0, req.size};
        fits     = no_limit || (want <= {1'b0, limit});
        fwd      = req.valid && fits;
        delayed  = req.valid && !fits;
        sum      = {1'b0, load_ff};
        if (fwd) begin
            sum = want;
        end
        if (cpl.valid) begin
            sum = (sum > {1'b0, cpl.size}) ? sum - {1'b0, cpl.size} : 17'h0;
        end
        // Saturate: an unlimited path may commit more than 16 bits count
        nxt_load = sum[16] ? 16'hffff : sum[15:0];
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_ff <= 16'h0;
        end else begin
            load_ff <= nxt_load;
        end
    end

    assign load = load_ff;

endmodule : stpcr_limit_chk

/* dv/stpcr_regs_props.sv */
// Port assertions for the split/PM capability register group
`timescale 1ns/10ps
`include "stpcr_consts.svh"

module stpcr_regs_props
    import stpcr_pkg::*;
(
    input wire logic                     ref_clk,
    input wire logic                     rst_b,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [`STPCR_ADDR_W-1:0] paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input stpcr_split_t                  up_req,
    input stpcr_split_t                  dn_req,
    input wire logic                     up_fwd,
    input wire logic                     dn_fwd
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    logic rd_setup;
    logic known;
    assign rd_setup = psel && !penable && !pwrite;
    assign known = paddr inside {12'h07c, 12'h080, 12'h088, 12'h08c, 12'h090};

    logic        wr_acc;
    logic [15:0] up_lim_sh;
    logic [15:0] dn_lim_sh;
    assign wr_acc = psel && penable && pwrite;

    // Shadow limits follow the bus only, never the design's registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_lim_sh <= `STPCR_SPLIT_LIM_RST;
            dn_lim_sh <= `STPCR_SPLIT_LIM_RST;
        end else if (wr_acc && pready) begin
            if (paddr == 12'h088) begin
                up_lim_sh <= {pstrb[3] ? pwdata[31:24] : up_lim_sh[15:8],
                              pstrb[2] ? pwdata[23:16] : up_lim_sh[7:0]};
            end
            if (paddr == 12'h08c) begin
                dn_lim_sh <= {pstrb[3] ? pwdata[31:24] : dn_lim_sh[15:8],
                              pstrb[2] ? pwdata[23:16] : dn_lim_sh[7:0]};
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    pready_on_a: assert property (pready)
        else $error("pready low");
    err_phase_a: assert property (
        pslverr |-> psel && penable)
        else $error("pslverr outside access");
    bad_addr_a: assert property (
        psel && penable && !known |-> pslverr)
        else $error("unmapped without error");
    good_addr_a: assert property (
        psel && penable && known |-> !pslverr)
        else $error("mapped with error");
    up_cap_a: assert property (
        rd_setup && paddr == 12'h088 |=> prdata[15:0] == 16'h0010)
        else $error("upstream capability wrong");
    dn_cap_a: assert property (
        rd_setup && paddr == 12'h08c |=> prdata[15:0] == 16'h0010)
        else $error("downstream capability wrong");
    pm_id_a: assert property (
        rd_setup && paddr == 12'h090 |=> prdata[7:0] == 8'h01)
        else $error("capability id wrong");
    next_link_a: assert property (
        rd_setup && paddr == 12'h090 |=> prdata[15:8] == 8'ha8)
        else $error("next pointer wrong");
    pm_caps_a: assert property (
        rd_setup && paddr == 12'h090 |=> prdata[31:16] == 16'hc802)
        else $error("capability word wrong");
    up_fwd_req_a: assert property (up_fwd |-> up_req.valid)
        else $error("upstream forward without request");
    dn_fwd_req_a: assert property (dn_fwd |-> dn_req.valid)
        else $error("downstream forward without request");
    up_lim_rd_a: assert property (
        rd_setup && paddr == 12'h088 |=> prdata[31:16] == up_lim_sh)
        else $error("upstream limit readback wrong");
    dn_lim_rd_a: assert property (
        rd_setup && paddr == 12'h08c |=> prdata[31:16] == dn_lim_sh)
        else $error("downstream limit readback wrong");
    up_no_limit_a: assert property (
        up_lim_sh == 16'hffff && up_req.valid |-> up_fwd)
        else $error("upstream unlimited request held");
    dn_no_limit_a: assert property (
        dn_lim_sh == 16'hffff && dn_req.valid |-> dn_fwd)
        else $error("downstream unlimited request held");
endmodule : stpcr_regs_props

bind stpcr_regs stpcr_regs_props u_props (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .up_req(up_req), .dn_req(dn_req),
    .up_fwd(up_fwd), .dn_fwd(dn_fwd)
);

/* dv/stpcr_regs_bench.sv */
// Self-checking bench for the split/PM capability register group
`timescale 1ns/10ps
`include "stpcr_consts.svh"

module stpcr_regs_bench
    import stpcr_pkg::*;
;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] q;
        logic        e;
    } stpcr_row_t;

    logic         ref_clk = 1'b0;
    logic         rst_b   = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [11:0]  paddr   = 12'h000;
    logic [31:0]  pwdata  = 32'h0;
    logic [3:0]   pstrb   = 4'h0;
    logic [31:0]  prdata, rd_data;
    logic         pready, pslverr, rd_err, up_fwd, dn_fwd;
    stpcr_split_t up_req = '0, up_cpl = '0, dn_req = '0, dn_cpl = '0;
    int           err_total = 0, tests_run = 0, cyc = 0;

    // Write, then read back; partial strobes and read-only words included
    stpcr_row_t rows [6] = '{
        '{12'h088, 32'hffff_ffff, 4'hf, 32'hffff_0010, 1'b0},
        '{12'h088, 32'h0020_0000, 4'h4, 32'hff20_0010, 1'b0},
        '{12'h08c, 32'h0005_1234, 4'hf, 32'h0005_0010, 1'b0},
        '{12'h090, 32'h0000_0000, 4'hf, 32'hc802_a801, 1'b0},
        '{12'h07c, 32'hffff_ffff, 4'hf, 32'h0000_0000, 1'b0},
        '{12'h040, 32'h1234_5678, 4'hf, 32'h0000_0000, 1'b1}
    };

    stpcr_regs dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .up_req(up_req), .up_cpl(up_cpl), .up_fwd(up_fwd),
        .dn_req(dn_req), .dn_cpl(dn_cpl), .dn_fwd(dn_fwd)
    );

    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Slave may stretch the access phase; only the global timeout ends it
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        check(rd_data, exp);
    endtask : rd

    // Request held one cycle; forward decision sampled mid-cycle
    task automatic offer(input logic dn, input logic [15:0] sz,
                         input logic exp);
        @(posedge ref_clk);
        if (dn) begin
            dn_req <= '{1'b1, sz};
        end else begin
            up_req <= '{1'b1, sz};
        end
        @(negedge ref_clk);
        check({31'h0, dn ? dn_fwd : up_fwd}, {31'h0, exp});
        @(posedge ref_clk);
        up_req <= '0;
        dn_req <= '0;
    endtask : offer

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            check({31'h0, rd_err}, {31'h0, rows[i].e});
            apb(1'b0, rows[i].a, 32'h0, 4'h0);
            check(rd_data, rows[i].q);
        end
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(12'h088, 32'h0010_0010);
        rd(12'h08c, 32'h0010_0010);
        offer(1'b0, 16'h0010, 1'b1);
        offer(1'b0, 16'h0001, 1'b0);
        rd(12'h07c, 32'h0000_0010);
        rd(12'h080, 32'h0000_0001);
        apb(1'b1, 12'h080, 32'h0000_0001, 4'h1);
        rd(12'h080, 32'h0000_0000);
        @(posedge ref_clk);
        up_cpl <= '{1'b1, 16'h0010};
        @(posedge ref_clk);
        up_cpl <= '0;
        offer(1'b0, 16'h0010, 1'b1);
        apb(1'b1, 12'h08c, 32'hffff_0000, 4'hc);
        offer(1'b1, 16'hffff, 1'b1);
        offer(1'b1, 16'h0010, 1'b1);
        rd(12'h07c, 32'hffff_0010);
        apb(1'b1, 12'h08c, 32'h0000_0000, 4'hc);
        offer(1'b1, 16'h0001, 1'b0);
        rd(12'h080, 32'h0000_0002);
        // Clear and a fresh delay at one edge: the set must win
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= 12'h080;
        pwdata <= 32'h0000_0003;
        pstrb <= 4'h1;
        @(posedge ref_clk);
        penable <= 1'b1;
        up_req <= '{1'b1, 16'h0001};
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        up_req <= '0;
        rd(12'h080, 32'h0000_0001);
        finish_test();
    end
endmodule : stpcr_regs_bench
